// ---- design/prot_gate_pkg.sv ----
package prot_gate_pkg;

  // ------------------------------------------------------------
  // Bus geometry
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W  = 8;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_CMD       = 8'h00;  // Protection command, write only
  localparam logic [7:0] OFF_STATUS    = 8'h04;  // System status
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h08;  // Sticky event bits, write one to clear
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h0c;  // Event enables
  localparam logic [7:0] OFF_BITOP     = 8'h10;  // Single-bit manipulation port
  localparam logic [7:0] OFF_SPEC_BASE = 8'h40;  // First protected register
  localparam logic [7:0] OFF_PLAIN_BASE = 8'h80; // First unprotected register

  // ------------------------------------------------------------
  // Default register counts
  // ------------------------------------------------------------
  localparam int NUM_SPECIAL = 8;
  localparam int NUM_PLAIN   = 4;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int STATUS_ERR_BIT = 0;  // Protection error flag
  localparam int IRQ_ERR_BIT    = 0;  // Event: protection error raised
  localparam int IRQ_SPEC_BIT   = 1;  // Event: protected write accepted
  localparam int IRQ_W          = 2;
  localparam int BITOP_BIT_LSB  = 0;  // Bit number, 3 bits
  localparam int BITOP_OP_LSB   = 4;  // Operation, 2 bits
  localparam int BITOP_TGT_LSB  = 8;  // Target byte offset, 8 bits

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0]        STATUS_RESET   = 8'h00;
  localparam logic [7:0]        REG_RESET      = 8'h00;
  localparam logic [IRQ_W-1:0]  IRQ_MASK_RESET = 2'h0;

  // ------------------------------------------------------------
  // Bit operations and bus answers
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    BIT_SET, BIT_CLEAR, BIT_INVERT, BIT_NONE
  } bitop_t;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- design/protected_register_write_gate.sv ----
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
`default_nettype none

module protected_register_write_gate #(
  parameter int NSPEC  = prot_gate_pkg::NUM_SPECIAL,
  parameter int NPLAIN = prot_gate_pkg::NUM_PLAIN
) (
  input  wire logic                          mclk,
  input  wire logic                          reset_n,
  input  wire logic [prot_gate_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]                    s_axi_awprot,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [prot_gate_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [prot_gate_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]                    s_axi_arprot,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [prot_gate_pkg::DATA_W-1:0]   s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  output logic                               irq,
  output logic                               interruptHold,
  output logic                               protectionError
);
  import prot_gate_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic                        awHeld;
    logic [ADDR_W-1:0]           awAddr;
    logic                        wHeld;
    logic [15:0]                 wData;
    logic                        wLane0;
    logic                        bValid;
    logic [1:0]                  bResp;
    logic                        rValid;
    logic [REG_W-1:0]            rData;
    logic [1:0]                  rResp;
    logic                        armed;
    logic                        errFlag;
    logic [IRQ_W-1:0]            irqStat;
    logic [IRQ_W-1:0]            irqMask;
    logic [NSPEC-1:0][REG_W-1:0]  spec;
    logic [NPLAIN-1:0][REG_W-1:0] plain;
  } state_t;

  state_t s_reg;
  state_t s_next;

  // Decoded target of a register access
  typedef struct packed {
    logic       mapped;
    logic       isCmd;
    logic       isStatus;
    logic       isIrqStat;
    logic       isIrqMask;
    logic       isSpec;
    logic       isPlain;
    logic [7:0] idx;
  } target_t;

  // ------------------------------------------------------------
  // Address decode and readback
  // ------------------------------------------------------------
  function automatic target_t decode(input logic [7:0] a);
    target_t t;
    t = '0;
    if (a == OFF_CMD) begin
      t.isCmd = 1'b1;
    end else if (a == OFF_STATUS) begin
      t.isStatus = 1'b1;
    end else if (a == OFF_IRQ_STAT) begin
      t.isIrqStat = 1'b1;
    end else if (a == OFF_IRQ_MASK) begin
      t.isIrqMask = 1'b1;
    end else if (a >= OFF_SPEC_BASE && a < 8'(OFF_SPEC_BASE + 4 * NSPEC) && a[1:0] == 2'h0) begin
      t.isSpec = 1'b1;
      t.idx    = 8'((a - OFF_SPEC_BASE) >> 2);
    end else if (a >= OFF_PLAIN_BASE && a < 8'(OFF_PLAIN_BASE + 4 * NPLAIN)
                 && a[1:0] == 2'h0) begin
      t.isPlain = 1'b1;
      t.idx     = 8'((a - OFF_PLAIN_BASE) >> 2);
    end
    t.mapped = t.isCmd | t.isStatus | t.isIrqStat | t.isIrqMask | t.isSpec | t.isPlain;
    return t;
  endfunction

  // Command register reads as zero; flag is the only live status bit
  function automatic logic [7:0] readBack(input state_t st, input target_t t);
    logic [7:0] v;
    v = 8'h00;
    if (t.isStatus) begin
      v[STATUS_ERR_BIT] = st.errFlag;
    end else if (t.isIrqStat) begin
      v[IRQ_W-1:0] = st.irqStat;
    end else if (t.isIrqMask) begin
      v[IRQ_W-1:0] = st.irqMask;
    end else if (t.isSpec) begin
      v = st.spec[t.idx[$clog2(NSPEC+1)-1:0]];
    end else if (t.isPlain) begin
      v = st.plain[t.idx[$clog2(NPLAIN+1)-1:0]];
    end
    return v;
  endfunction

  // ------------------------------------------------------------
  // Write target, value and classification
  // ------------------------------------------------------------
  logic       wrFire;
  logic       isBitop;
  logic [7:0] effAddr;
  target_t    wt;
  target_t    rt;
  logic [7:0] oldVal;
  logic [7:0] newVal;
  logic [2:0] bitNum;
  bitop_t     bitOp;
  logic       doWrite;
  logic       rdFire;

  // A bit operation is a read-modify-write of the target byte
  always_comb begin
    wrFire  = s_reg.awHeld && s_reg.wHeld && !s_reg.bValid;
    isBitop = (s_reg.awAddr == OFF_BITOP);
    effAddr = isBitop ? s_reg.wData[BITOP_TGT_LSB +: 8] : s_reg.awAddr;
    wt      = decode(effAddr);
    if (isBitop && wt.isCmd) begin
      wt = '0;
    end
    bitNum  = s_reg.wData[BITOP_BIT_LSB +: 3];
    bitOp   = bitop_t'(s_reg.wData[BITOP_OP_LSB +: 2]);
    oldVal  = readBack(s_reg, wt);
    newVal  = oldVal;
    if (isBitop) begin
      case (bitOp)
        BIT_SET:    newVal[bitNum] = 1'b1;
        BIT_CLEAR:  newVal[bitNum] = 1'b0;
        BIT_INVERT: newVal[bitNum] = ~oldVal[bitNum];
        default:    newVal = oldVal;
      endcase
    end else if (s_reg.wLane0) begin
      newVal = s_reg.wData[7:0];
    end
    // Upper lanes alone change nothing and leave the sequence alone, except at the bit-operation port
    doWrite = wrFire && wt.mapped && (isBitop || s_reg.wLane0);
    rt      = decode(s_axi_araddr);
    rdFire  = s_axi_arvalid && !s_reg.rValid;
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    // Channel capture, one write and one read at a time
    if (s_axi_awvalid && !s_reg.awHeld) begin
      s_next.awHeld = 1'b1;
      s_next.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_reg.wHeld) begin
      s_next.wHeld  = 1'b1;
      s_next.wData  = s_axi_wdata[15:0];
      s_next.wLane0 = s_axi_wstrb[0];
    end
    if (s_reg.bValid && s_axi_bready) begin
      s_next.bValid = 1'b0;
    end
    if (s_reg.rValid && s_axi_rready) begin
      s_next.rValid = 1'b0;
    end
    // Reads never touch the arming state
    if (rdFire) begin
      s_next.rValid = 1'b1;
      s_next.rData  = readBack(s_reg, rt);
      s_next.rResp  = rt.mapped ? RESP_OKAY : RESP_SLVERR;
    end
    if (wrFire) begin
      s_next.awHeld = 1'b0;
      s_next.wHeld  = 1'b0;
      s_next.bValid = 1'b1;
      s_next.bResp  = wt.mapped ? RESP_OKAY : RESP_SLVERR;
    end
    if (doWrite) begin
      // Any write following the command disarms, pass or fail
      s_next.armed = 1'b0;
      if (wt.isCmd) begin
        if (s_reg.armed) begin
          s_next.errFlag = 1'b1;
        end else begin
          s_next.armed = 1'b1;
        end
      end else if (wt.isSpec) begin
        if (s_reg.armed) begin
          s_next.spec[wt.idx[$clog2(NSPEC+1)-1:0]] = newVal;
        end else begin
          s_next.errFlag = 1'b1;
        end
      end else begin
        if (wt.isStatus) begin
          // Writing one cannot set the flag; zero clears it
          s_next.errFlag = s_reg.errFlag & newVal[STATUS_ERR_BIT];
        end else if (wt.isIrqMask) begin
          s_next.irqMask = newVal[IRQ_W-1:0];
        end else if (wt.isPlain) begin
          s_next.plain[wt.idx[$clog2(NPLAIN+1)-1:0]] = newVal;
        end
        // A clearing status write wins over the armed-write error
        if (s_reg.armed && !(wt.isStatus && !newVal[STATUS_ERR_BIT])) begin
          s_next.errFlag = 1'b1;
        end
      end
    end
    // Sticky events; a new event beats a same-cycle clear
    if (doWrite && wt.isIrqStat) begin
      s_next.irqStat = s_reg.irqStat & ~newVal[IRQ_W-1:0];
    end
    if (s_next.errFlag && !s_reg.errFlag) begin
      s_next.irqStat[IRQ_ERR_BIT] = 1'b1;
    end
    if (doWrite && wt.isSpec && s_reg.armed) begin
      s_next.irqStat[IRQ_SPEC_BIT] = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_reg         <= '0;
      s_reg.errFlag <= STATUS_RESET[STATUS_ERR_BIT];
      s_reg.irqMask <= IRQ_MASK_RESET;
      s_reg.spec    <= {NSPEC{REG_RESET}};
      s_reg.plain   <= {NPLAIN{REG_RESET}};
    end else begin
      s_reg <= s_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Ready only while the holding slot is free; this stalls the master
  assign s_axi_awready   = !s_reg.awHeld;
  assign s_axi_wready    = !s_reg.wHeld;
  assign s_axi_arready   = !s_reg.rValid;
  assign s_axi_bvalid    = s_reg.bValid;
  assign s_axi_bresp     = s_reg.bResp;
  assign s_axi_rvalid    = s_reg.rValid;
  assign s_axi_rresp     = s_reg.rResp;
  assign s_axi_rdata     = {{(DATA_W-REG_W){1'b0}}, s_reg.rData};
  assign protectionError = s_reg.errFlag;
  // Held from the command store until the next write lands
  assign interruptHold   = s_reg.armed;
  assign irq             = |(s_reg.irqStat & s_reg.irqMask);

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  // Protected registers move only inside an armed sequence
  a_spec_unarmed_keep: assert property (
    doWrite && wt.isSpec && !s_reg.armed
      |=> s_reg.spec == $past(s_reg.spec))
    else $error("protected register changed without command");
  a_spec_unarmed_err: assert property (
    doWrite && wt.isSpec && !s_reg.armed
      |=> protectionError ##1 (protectionError || $past(doWrite)))
    else $error("unarmed protected write left flag clear");

  // Armed plain and mask writes raise the flag; reads leave arming alone
  a_plain_armed_err: assert property (
    doWrite && s_reg.armed && (wt.isPlain || wt.isIrqMask)
      |=> protectionError && !interruptHold)
    else $error("armed plain write did not raise error");
  a_read_keeps_arm: assert property (
    rdFire && !doWrite |=> s_reg.armed == $past(s_reg.armed))
    else $error("read changed arming");

  // Software clearing, and its priority over the armed-write error
  a_zero_clears: assert property (
    doWrite && wt.isStatus && !newVal[STATUS_ERR_BIT] |=> !protectionError)
    else $error("zero write did not clear flag");
  a_one_keeps_clear: assert property (
    doWrite && wt.isStatus && !s_reg.armed && !s_reg.errFlag |=> !protectionError)
    else $error("status write set the flag");
  a_clear_wins: assert property (
    doWrite && s_reg.armed && wt.isStatus && !newVal[0]
      |=> !protectionError && !interruptHold)
    else $error("armed zero write left flag set");
  a_double_cmd: assert property (
    doWrite && wt.isCmd && s_reg.armed |=> protectionError && !interruptHold)
    else $error("second command write not flagged");

  // Arming around the command store; refused writes are inert
  a_cmd_holds_irq: assert property (
    doWrite && wt.isCmd && !s_reg.armed |=> interruptHold throughout (!doWrite)[*1])
    else $error("command write did not hold interrupts");
  a_write_disarms: assert property (
    doWrite && !wt.isCmd |=> !interruptHold)
    else $error("write left sequence armed");
  a_refused_inert: assert property (
    wrFire && !wt.mapped |=> $stable(interruptHold) && $stable(protectionError))
    else $error("refused write changed the sequence");
  a_error_event: assert property (
    $rose(protectionError) |-> s_reg.irqStat[IRQ_ERR_BIT])
    else $error("error flag rose without event bit");

  // Readback and bus answers
  a_status_upper: assert property (
    rdFire && rt.isStatus |=> s_axi_rvalid && s_axi_rdata[7:1] == 7'h00)
    else $error("status upper bits not zero");
  a_cmd_read_zero: assert property (
    rdFire && rt.isCmd |=> s_axi_rdata == 32'h0 && $stable(interruptHold))
    else $error("command read visible");
  a_write_answer: assert property (
    wrFire |=> s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write not answered next cycle");

  // Next write lands a few cycles after the command, behind the answer
  c_armed_special: cover property (doWrite && wt.isCmd && !s_reg.armed
    ##[2:20] doWrite && wt.isSpec && s_reg.armed);
  c_unarmed_err: cover property (doWrite && wt.isSpec && !s_reg.armed);
  c_clear_priority: cover property (doWrite && s_reg.armed && wt.isStatus && !newVal[0]);
  c_bitop_status: cover property (doWrite && isBitop && wt.isStatus);
  c_read_armed: cover property (rdFire && s_reg.armed);

endmodule

`default_nettype wire

// ---- test/cpu_bus_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------
// Processor core issuing stores and loads
// ----------
module cpu_bus_model (
  input  wire logic        mclk,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready,
  output logic             hung
);
  // Idle bus; released lines show the inverse so stale values never pass
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, hung} = '0;
  end

  // Store: one outstanding, next one only after the answer
  task automatic store(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge mclk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 100) hung <= 1'b1;
  endtask

  // Load; reads never disturb an armed sequence
  task automatic load(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge mclk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 100) hung <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- test/tb_protected_register_write_gate.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_protected_register_write_gate;
  import prot_gate_pkg::*;
  localparam logic [7:0] AMAP [17] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h40, 8'h44, 8'h48,
    8'h4c, 8'h50, 8'h54, 8'h58, 8'h5c, 8'h80, 8'h84, 8'h88, 8'h8c};
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  awaddr, araddr, a;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, ist, msk;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid;
  logic        rready, irq, interruptHold, protectionError, hung;
  int          fail_count = 0;
  int          num_checks = 0;
  int          err, armed;
  logic [7:0]  spec [8];
  logic [7:0]  plain [4];

  initial begin
    forever #10 mclk = ~mclk;
  end

  protected_register_write_gate dut_u (.mclk(mclk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq), .interruptHold(interruptHold),
    .protectionError(protectionError));
  cpu_bus_model cpu_u (.mclk(mclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .hung(hung));

  // ----------
  // Reference model
  // ----------
  function automatic bit mapped(logic [7:0] x);
    return x inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10} || x[1:0] == 2'h0 &&
      (x[7:5] == 3'h2 || x[7:4] == 4'h8);
  endfunction
  function automatic logic [7:0] peek(logic [7:0] x);
    if (!mapped(x)) return 8'h00;
    case (x)
      OFF_STATUS:   return {7'h00, err[0]};
      OFF_IRQ_STAT: return {6'h00, ist};
      OFF_IRQ_MASK: return {6'h00, msk};
      default:      return x[7] ? plain[x[3:2]] : x[6] ? spec[x[4:2]] : 8'h00;
    endcase
  endfunction
  function automatic void seterr();
    if (err == 0) ist[0] = 1'b1;
    err = 1;
  endfunction
  task automatic model_wr(logic [7:0] x, logic [31:0] y, output logic [1:0] r);
    logic [7:0] t, v;
    t = (x == OFF_BITOP) ? y[15:8] : x;
    r = RESP_SLVERR;
    if (!mapped(x) || !mapped(t) || x == OFF_BITOP && t inside {OFF_CMD, OFF_BITOP}) return;
    r = RESP_OKAY;
    v = (x == OFF_BITOP) ? peek(t) : y[7:0];
    if (x == OFF_BITOP) begin
      case (y[5:4])
        2'h0:    v[y[2:0]] = 1'b1;
        2'h1:    v[y[2:0]] = 1'b0;
        2'h2:    v[y[2:0]] = ~v[y[2:0]];
        default: ;
      endcase
    end
    if (t == OFF_CMD) begin
      if (armed) seterr();
      armed = !armed;
      return;
    end
    if (t[7:5] == 3'h2) begin
      if (armed) spec[t[4:2]] = v;
      if (armed) ist[1] = 1'b1;
      else seterr();
    end else begin
      if (t == OFF_STATUS) err = err & v[0];
      if (t == OFF_IRQ_STAT) ist = ist & ~v[1:0];
      if (t == OFF_IRQ_MASK) msk = v[1:0];
      if (t[7]) plain[t[3:2]] = v;
      if (armed && !(t == OFF_STATUS && !v[0])) seterr();
    end
    armed = 0;
  endtask

  // ----------
  // Checking and sequencing
  // ----------
  task automatic check(string n, logic [31:0] e, logic [31:0] s);
    num_checks++;
    if (e !== s) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Every access compared with the model, flags included
  task automatic op(bit wr, logic [7:0] x, logic [31:0] y);
    logic [1:0] r, er;
    logic [31:0] q;
    if (wr) cpu_u.store(x, y, r);
    if (wr) model_wr(x, y, er);
    else cpu_u.load(x, q, r);
    // The bit-operation port is write only and refuses reads
    if (!wr) er = mapped(x) && x != OFF_BITOP ? RESP_OKAY : RESP_SLVERR;
    if (!wr) check("rdata", {24'h0, peek(x)}, q);
    #1;
    check("resp", er, r);
    check("flag", err[0], protectionError);
    check("hold", armed[0], interruptHold);
    check("irq", |(ist & msk), irq);
  endtask
  // Reset is launched at an edge so the release never races the bus
  task automatic do_reset;
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    {err, armed, ist, msk} = '0;
    foreach (spec[i]) spec[i] = 8'h00;
    foreach (plain[i]) plain[i] = 8'h00;
  endtask

  // A stalled bus counts as a failure and ends the run
  always @(posedge hung) begin
    fail_count++;
    conclude();
  end

  initial begin
    void'($urandom(32'h3c0e08b1));
    do_reset();
    foreach (AMAP[i]) op(0, AMAP[i], 0);
    op(0, 8'h60, 0);
    op(1, 8'h41, 1);
    $display("test reset and map done");
    op(1, 8'h44, 8'h5a);
    op(1, OFF_STATUS, 1);
    op(1, OFF_STATUS, 0);
    op(1, OFF_CMD, 8'h02);
    op(0, 8'h80, 0);
    op(1, 8'h48, 8'ha5);
    op(1, OFF_CMD, 8'h02);
    op(1, 8'h84, 8'h3c);
    op(1, OFF_CMD, 8'h02);
    op(1, OFF_BITOP, 32'h8403);
    op(1, OFF_CMD, 8'h02);
    op(1, OFF_STATUS, 0);
    op(1, OFF_IRQ_MASK, 3);
    op(1, OFF_CMD, 8'h02);
    op(1, OFF_CMD, 8'h02);
    op(1, 8'h4c, 8'h77);
    op(1, OFF_IRQ_STAT, 1);
    op(1, OFF_BITOP, 32'h0410);
    op(1, OFF_CMD, 8'h02);
    op(1, OFF_BITOP, 32'h0000);
    op(1, 8'h4c, 8'h11);
    $display("test sequences done");
    for (int k = 0; k < 4; k++) begin
      op(1, OFF_CMD, k);
      op(1, OFF_BITOP, {16'h0, 8'h58, 2'h0, k[1:0], 1'b0, k[2:0]});
    end
    repeat (300) begin
      a = AMAP[$urandom_range(16)];
      d = $urandom;
      if (a == OFF_BITOP) d[15:8] = AMAP[$urandom_range(16)];
      if (d[15:8] == OFF_IRQ_STAT) d[15:8] = 8'h50;
      if ($urandom_range(3) == 0) op(1, OFF_CMD, d);
      op($urandom_range(1), a, d);
    end
    $display("test random traffic done");
    // Two protected-register writes leave the flag set whatever arming was left
    op(1, 8'h40, 0);
    op(1, 8'h44, 0);
    check("flag before reset", 1, protectionError);
    do_reset();
    op(0, OFF_STATUS, 0);
    $display("test second reset done");
    conclude();
  end
endmodule
`default_nettype wire
